// ---- core/cbt_bit_timing.sv ----
// can bit timing and synchronisation core with its timing registers
// assumes: all inputs synchronous to CORE_CLK, bus idle and tx level come
// from the protocol engine, software writes timing only in config mode
//
// Notes on behaviour
// - quantum is clock over two times prescale plus one
// - bit spans 5 to 25 quanta, 8 recommended
// - each bit opens with one-quantum sync segment
// - propagation segment 1 to 8 quanta
// - phase 1 is 1 to 8; sample at its end
// - phase 2 is 1 to 8, never below 2
// - phase 2 source: own field or max(phase1, 2)
// - two quanta processing time after the sample point
// - triple mode takes three samples half quantum apart
// - sample mode bit picks triple or single sample
// - hard sync on falling edge while idle restarts bit
// - no resync after hard sync in same bit
// - jump width 1 to 4 quanta
// - only recessive to dominant edges synchronise
// - phase error zero, positive or negative by position
// - error within jump width restarts the bit time
// - large positive error lengthens phase 1 by width
// - large negative error shortens phase 2 by width
// - at most one synchronisation per bit time
// - edge used only if previous sample was recessive
// - no positive-error resync while sending dominant
// - timing writable only in configuration mode
`timescale 1ns/1ps
`default_nettype none
`include "cbt_regs.svh"
module cbt_bit_timing
  import cbt_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [`CBT_ADDR_W-1:0] ADDR,
  input wire logic [`CBT_DATA_W-1:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [`CBT_DATA_W-1:0] RD_DATA,
  input wire logic BUS_RECEIVE_PIN,
  input wire logic BUS_IDLE,
  input wire logic TX_DOMINANT,
  output logic SAMPLE_STB,
  output logic SAMPLE_BIT,
  output logic BIT_START_STB
);
  cbt_cfg_t cfg_q;
  logic cfg_mode_q;
  cbt_seg_t seg_q;
  logic [6:0] pre_q;
  logic [4:0] tq_q;
  logic [2:0] ext_q;
  logic [2:0] cut_q;
  logic synced_q;
  logic last_bit_q;
  logic rx_prev_q;
  logic [`CBT_DATA_W-1:0] rd_q;
  logic samp_q;
  logic bit_q;
  logic start_q;

  logic [6:0] pre_top;
  logic tq_tick;
  logic half_tick;
  logic [4:0] prop_len;
  logic [4:0] ph1_base;
  logic [4:0] ph1_eff;
  logic [4:0] ph2_base;
  logic [4:0] ph2_eff;
  logic [4:0] sjw_len;
  logic fall_edge;
  logic edge_ok;
  logic hard_sync;
  logic resync;
  logic is_pos;
  logic [4:0] err_mag;
  logic restart;
  logic lengthen;
  logic shorten;
  logic sample_pt;
  logic bit_end;
  logic maj_bit;

  ////////////////////////////////////////////////////////////////////////////
  // register port

  // timing fields are frozen outside config mode so a live bit never tears
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      cfg_q <= {`CBT_TIME0_RST, `CBT_TIME1_RST, 3'(`CBT_TIME2_RST)};
      cfg_mode_q <= `CBT_CFGMODE_RST;
    end else if (CE && WR_STB) begin
      if (ADDR == `CBT_OFS_CTRL) begin
        cfg_mode_q <= WR_DATA[`CBT_CFGMODE_BIT];
      end else if (cfg_mode_q && ADDR == `CBT_OFS_TIME0) begin
        cfg_q.quantum_prescale <= WR_DATA[`CBT_PRESC_LSB +: 6];
        cfg_q.jump_width <= WR_DATA[`CBT_JUMP_LSB +: 2];
      end else if (cfg_mode_q && ADDR == `CBT_OFS_TIME1) begin
        cfg_q.prop_segment_len <= WR_DATA[`CBT_PROP_LSB +: 3];
        cfg_q.phase1_len <= WR_DATA[`CBT_PH1_LSB +: 3];
        cfg_q.triple_sample_select <= WR_DATA[`CBT_TRIPLE_BIT];
        cfg_q.phase2_source_select <= WR_DATA[`CBT_P2SRC_BIT];
      end else if (cfg_mode_q && ADDR == `CBT_OFS_TIME2) begin
        cfg_q.phase2_len <= WR_DATA[`CBT_PH2_LSB +: 3];
      end
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      rd_q <= 8'h00;
    end else if (CE) begin
      rd_q <= 8'h00;
      if (RD_STB) begin
        case (ADDR)
          `CBT_OFS_TIME0: rd_q <= {cfg_q.jump_width, cfg_q.quantum_prescale};
          `CBT_OFS_TIME1: rd_q <= {cfg_q.phase2_source_select, cfg_q.triple_sample_select,
                                   cfg_q.phase1_len, cfg_q.prop_segment_len};
          `CBT_OFS_TIME2: rd_q <= {5'h00, cfg_q.phase2_len};
          `CBT_OFS_CTRL: rd_q <= {7'h00, cfg_mode_q};
          `CBT_OFS_STAT: rd_q <= {3'h0, synced_q, last_bit_q, BUS_RECEIVE_PIN, seg_q};
          default: rd_q <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // quantum generation and segment lengths

  assign pre_top = {cfg_q.quantum_prescale, 1'b1};
  assign tq_tick = (pre_q == pre_top);
  assign half_tick = tq_tick | (pre_q == {1'b0, cfg_q.quantum_prescale});
  assign prop_len = {2'h0, cfg_q.prop_segment_len} + 5'h01;
  assign ph1_base = {2'h0, cfg_q.phase1_len} + 5'h01;
  assign ph1_eff = ph1_base + {2'h0, ext_q};
  assign sjw_len = {3'h0, cfg_q.jump_width} + 5'h01;

  // a phase 2 under two quanta would eat into the processing time
  always_comb begin
    if (cfg_q.phase2_source_select) begin
      ph2_base = {2'h0, cfg_q.phase2_len} + 5'h01;
    end else begin
      ph2_base = ph1_base;
    end
    if (ph2_base < `CBT_IPT_TQ) begin
      ph2_base = `CBT_IPT_TQ;
    end
  end
  assign ph2_eff = ph2_base - {2'h0, cut_q};

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pre_q <= 7'h00;
    end else if (CE) begin
      if (cfg_mode_q || restart || tq_tick) begin
        pre_q <= 7'h00;
      end else begin
        pre_q <= pre_q + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge qualification and phase error

  assign fall_edge = rx_prev_q & ~BUS_RECEIVE_PIN;
  assign edge_ok = fall_edge & last_bit_q & ~synced_q & ~cfg_mode_q;
  assign hard_sync = edge_ok & BUS_IDLE;
  assign is_pos = (seg_q == CBT_PROP) || (seg_q == CBT_PH1);

  // zero in sync, quanta since sync before the sample point, else quanta left
  always_comb begin
    if (seg_q == CBT_PROP) begin
      err_mag = tq_q + 5'h01;
    end else if (seg_q == CBT_PH1) begin
      err_mag = prop_len + tq_q + 5'h01;
    end else if (seg_q == CBT_PH2) begin
      err_mag = ph2_eff - tq_q;
    end else begin
      err_mag = 5'h00;
    end
  end

  // an edge in sync has zero error: it spends the bit's sync but moves nothing
  assign resync = edge_ok & ~BUS_IDLE & (seg_q != CBT_SYNC)
                  & ~(is_pos & TX_DOMINANT);
  assign restart = hard_sync | (resync & (err_mag <= sjw_len));
  assign lengthen = resync & is_pos & (err_mag > sjw_len);
  assign shorten = resync & ~is_pos & (err_mag > sjw_len);

  assign sample_pt = tq_tick & ~restart & (seg_q == CBT_PH1) & (tq_q >= ph1_eff - 5'h01);
  assign bit_end = tq_tick & ~restart & (seg_q == CBT_PH2) & (tq_q >= ph2_eff - 5'h01);

  ////////////////////////////////////////////////////////////////////////////
  // segment sequencer

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      seg_q <= CBT_SYNC;
      tq_q <= 5'h00;
    end else if (CE) begin
      if (cfg_mode_q || restart) begin
        seg_q <= CBT_SYNC;
        tq_q <= 5'h00;
      end else if (tq_tick) begin
        tq_q <= tq_q + 5'h01;
        case (seg_q)
          CBT_SYNC: begin
            seg_q <= CBT_PROP;
            tq_q <= 5'h00;
          end
          CBT_PROP: begin
            if (tq_q >= prop_len - 5'h01) begin
              seg_q <= CBT_PH1;
              tq_q <= 5'h00;
            end
          end
          CBT_PH1: begin
            if (sample_pt) begin
              seg_q <= CBT_PH2;
              tq_q <= 5'h00;
            end
          end
          CBT_PH2: begin
            if (bit_end) begin
              seg_q <= CBT_SYNC;
              tq_q <= 5'h00;
            end
          end
          default: begin
            seg_q <= CBT_SYNC;
            tq_q <= 5'h00;
          end
        endcase
      end
    end
  end

  // adjustments and the sync flag live for one bit time only
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ext_q <= 3'h0;
      cut_q <= 3'h0;
      synced_q <= 1'b0;
    end else if (CE) begin
      if (cfg_mode_q || bit_end) begin
        ext_q <= 3'h0;
        cut_q <= 3'h0;
        synced_q <= 1'b0;
      end else if (restart) begin
        ext_q <= 3'h0;
        cut_q <= 3'h0;
        synced_q <= 1'b1;
      end else if (edge_ok && !BUS_IDLE) begin
        synced_q <= 1'b1;
        if (lengthen) begin
          ext_q <= sjw_len[2:0];
        end
        if (shorten) begin
          cut_q <= sjw_len[2:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sampling and strobes

  cbt_sampler u_sampler (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .ce(CE),
    .half_tick(half_tick),
    .rx(BUS_RECEIVE_PIN),
    .triple(cfg_q.triple_sample_select),
    .bit_val(maj_bit)
  );

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      rx_prev_q <= 1'b1;
      last_bit_q <= 1'b1;
      samp_q <= 1'b0;
      bit_q <= 1'b1;
      start_q <= 1'b0;
    end else if (CE) begin
      rx_prev_q <= BUS_RECEIVE_PIN;
      samp_q <= sample_pt;
      start_q <= restart | bit_end;
      if (sample_pt) begin
        last_bit_q <= maj_bit;
        bit_q <= maj_bit;
      end
    end
  end

  assign RD_DATA = rd_q;
  assign SAMPLE_STB = samp_q;
  assign SAMPLE_BIT = bit_q;
  assign BIT_START_STB = start_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_restart_seen;
    CE && restart && !cfg_mode_q;
  endsequence
  sequence s_bit_reopened;
    seg_q == CBT_SYNC && tq_q == 5'h00 && BIT_START_STB && synced_q;
  endsequence

  property p_hard_restart;
    s_restart_seen |=> s_bit_reopened;
  endproperty
  a_hard_restart: assert property (p_hard_restart) else $error("no bit restart");

  property p_sync_one_tq;
    CE && !cfg_mode_q && !restart && seg_q == CBT_SYNC && tq_tick |=> seg_q == CBT_PROP;
  endproperty
  a_sync_one_tq: assert property (p_sync_one_tq) else $error("sync not one quantum");

  property p_sample_strobe;
    CE && sample_pt |=> SAMPLE_STB && SAMPLE_BIT == $past(maj_bit) && seg_q == CBT_PH2;
  endproperty
  a_sample_strobe: assert property (p_sample_strobe) else $error("bad sample point");

  property p_ph2_floor;
    !cfg_q.phase2_source_select && cfg_q.phase1_len == 3'h0 |-> ph2_base == 5'h02;
  endproperty
  a_ph2_floor: assert property (p_ph2_floor) else $error("phase 2 below ipt");

  property p_only_falling;
    restart || lengthen || shorten |-> rx_prev_q && !BUS_RECEIVE_PIN && last_bit_q;
  endproperty
  a_only_falling: assert property (p_only_falling) else $error("bad sync edge");

  property p_single_sync;
    synced_q && !start_q |-> !(restart || lengthen || shorten);
  endproperty
  a_single_sync: assert property (p_single_sync) else $error("second sync in bit");

  property p_lengthen;
    CE && lengthen |=> ext_q == $past(sjw_len[2:0]) && ph1_eff == ph1_base + $past(sjw_len);
  endproperty
  a_lengthen: assert property (p_lengthen) else $error("phase 1 not lengthened");

  property p_shorten;
    CE && shorten |=> cut_q == $past(sjw_len[2:0]);
  endproperty
  a_shorten: assert property (p_shorten) else $error("phase 2 not shortened");

  property p_tx_no_pos;
    TX_DOMINANT && is_pos && !BUS_IDLE |-> !restart && !lengthen;
  endproperty
  a_tx_no_pos: assert property (p_tx_no_pos) else $error("resync while dominant");

  property p_cfg_lock;
    CE && WR_STB && !cfg_mode_q && ADDR != `CBT_OFS_CTRL |=> cfg_q == $past(cfg_q);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock) else $error("timing written live");
endmodule
`default_nettype wire

// ---- core/cbt_regs.svh ----
// register offsets, field positions, reset values and timing counts
// assumes: included by bare name from the bit timing module and the testbench
`ifndef CBT_REGS_SVH
`define CBT_REGS_SVH
`define CBT_ADDR_W 3
`define CBT_DATA_W 8
`define CBT_OFS_TIME0 3'h0
`define CBT_OFS_TIME1 3'h1
`define CBT_OFS_TIME2 3'h2
`define CBT_OFS_CTRL 3'h3
`define CBT_OFS_STAT 3'h4
`define CBT_PRESC_LSB 0
`define CBT_JUMP_LSB 6
`define CBT_PROP_LSB 0
`define CBT_PH1_LSB 3
`define CBT_TRIPLE_BIT 6
`define CBT_P2SRC_BIT 7
`define CBT_PH2_LSB 0
`define CBT_CFGMODE_BIT 0
`define CBT_TIME0_RST 8'h00
`define CBT_TIME1_RST 8'h00
`define CBT_TIME2_RST 8'h00
`define CBT_CFGMODE_RST 1'h1
`define CBT_IPT_TQ 5'h02
`endif

// ---- core/cbt_pkg.sv ----
// types shared by the bit timing modules
// assumes: cbt_regs.svh is on the include path
package cbt_pkg;
  typedef enum logic [1:0] {
    CBT_SYNC = 2'b00,
    CBT_PROP = 2'b01,
    CBT_PH1 = 2'b11,
    CBT_PH2 = 2'b10
  } cbt_seg_t;
  typedef struct packed {
    logic [1:0] jump_width;
    logic [5:0] quantum_prescale;
    logic phase2_source_select;
    logic triple_sample_select;
    logic [2:0] phase1_len;
    logic [2:0] prop_segment_len;
    logic [2:0] phase2_len;
  } cbt_cfg_t;
endpackage

// ---- core/cbt_sampler.sv ----
// bus sampler: single or three-sample majority decision
// assumes: half_tick pulses every half quantum, rx synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module cbt_sampler
  import cbt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic half_tick,
  input wire logic rx,
  input wire logic triple,
  output logic bit_val
);
  logic [1:0] hist_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hist_q <= 2'h3;
    end else if (ce && half_tick) begin
      hist_q <= {hist_q[0], rx};
    end
  end

  // the two older samples sit half a quantum apart, the third is taken now
  always_comb begin
    if (triple) begin
      bit_val = (hist_q[1] & hist_q[0]) | (hist_q[1] & rx) | (hist_q[0] & rx);
    end else begin
      bit_val = rx;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/cbt_bus_node.sv ----
// bus node model: drives the receive pin of the bit timing core
// assumes: pin is pulled up, so a released bus reads recessive
`timescale 1ns/1ps
`default_nettype none
module cbt_bus_node (
  input wire logic clk,
  output logic pin
);
  initial begin
    pin = 1'b1;
  end
  // dominant for n clocks, then released to the pull-up level
  task automatic pulse(input int n);
    pin <= 1'b0;
    repeat (n) @(posedge clk);
    pin <= 1'b1;
  endtask
  task automatic level(input logic v);
    pin <= v;
  endtask
endmodule
`default_nettype wire

// ---- testbench/cbt_bit_timing_tb.sv ----
// testbench: register port, bit lengths, sampling and synchronisation
// assumes: bus node model on the receive pin, engine levels driven here
`timescale 1ns/1ps
`default_nettype none
`include "cbt_regs.svh"
module cbt_bit_timing_tb;
  import cbt_pkg::*;
  logic CORE_CLK, RST_N, CE, WR_STB, RD_STB, BUS_IDLE, TX_DOMINANT;
  logic [2:0] ADDR;
  logic [7:0] WR_DATA, RD_DATA, d;
  logic BUS_RECEIVE_PIN, SAMPLE_STB, SAMPLE_BIT, BIT_START_STB, v, hit;
  cbt_cfg_t c;
  int n_fail, samples_checked, cnt, len, s_ofs, cyc, nom;

  cbt_bit_timing uut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CE(CE), .ADDR(ADDR),
    .WR_DATA(WR_DATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA),
    .BUS_RECEIVE_PIN(BUS_RECEIVE_PIN), .BUS_IDLE(BUS_IDLE), .TX_DOMINANT(TX_DOMINANT),
    .SAMPLE_STB(SAMPLE_STB), .SAMPLE_BIT(SAMPLE_BIT), .BIT_START_STB(BIT_START_STB));
  cbt_bus_node node (.clk(CORE_CLK), .pin(BUS_RECEIVE_PIN));

  initial begin
    CORE_CLK = 1'b0;
    forever #2.5 CORE_CLK = ~CORE_CLK;
  end
  // distance of each strobe from the last bit start strobe
  always @(posedge CORE_CLK) begin
    cnt <= BIT_START_STB ? 1 : cnt + 1;
    if (BIT_START_STB) len <= cnt;
    if (SAMPLE_STB) s_ofs <= cnt;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic int tq(cbt_cfg_t k);
    return 2 * (k.quantum_prescale + 1);
  endfunction
  function automatic int ph2q(cbt_cfg_t k);
    int p;
    p = (k.phase2_source_select ? k.phase2_len : k.phase1_len) + 1;
    return tq(k) * ((p < 2) ? 2 : p);
  endfunction
  function automatic int spq(cbt_cfg_t k);
    return tq(k) * (3 + k.prop_segment_len + k.phase1_len);
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] x);
    @(posedge CORE_CLK);
    ADDR <= a;
    WR_DATA <= x;
    WR_STB <= 1'b1;
    @(posedge CORE_CLK);
    WR_STB <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] x);
    @(posedge CORE_CLK);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge CORE_CLK);
    RD_STB <= 1'b0;
    #1 x = RD_DATA;
  endtask
  // timing fields go in only while config mode holds the engine
  task automatic set_cfg(input cbt_cfg_t k);
    wr(`CBT_OFS_CTRL, 8'h01);
    wr(`CBT_OFS_TIME0, {k.jump_width, k.quantum_prescale});
    wr(`CBT_OFS_TIME1, {k.phase2_source_select, k.triple_sample_select, k.phase1_len,
      k.prop_segment_len});
    wr(`CBT_OFS_TIME2, {5'h00, k.phase2_len});
    wr(`CBT_OFS_CTRL, 8'h00);
  endtask
  task automatic wait_stb(input bit s);
    int i;
    i = 0;
    do begin
      @(posedge CORE_CLK);
      i++;
    end while ((s ? SAMPLE_STB : BIT_START_STB) !== 1'b1 && i < 4000);
    if (i >= 4000) check("strobe wait", 0, 1);
  endtask
  task automatic bit_len(input int e, input string what);
    wait_stb(0);
    @(posedge CORE_CLK);
    check(what, len, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    RST_N = 1'b0;
    WR_STB = 1'b0;
    RD_STB = 1'b0;
    BUS_IDLE = 1'b0;
    TX_DOMINANT = 1'b0;
    ADDR = 3'h0;
    WR_DATA = 8'h00;
    CE = 1'b1;
    {n_fail, samples_checked, cnt, len, s_ofs, cyc} = '0;
    void'($urandom(24716));
    repeat (12) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    for (int k = 0; k < 8; k++) if (k != 4) begin
      rd(3'(k), d);
      check("reset reg", d, {7'h00, k == 3});
    end
    // random timing sets at the typical jump width, bits of 8 quanta or more
    for (int i = 0; i < 8; i++) begin
      c = 19'($urandom);
      c.jump_width = 2'h0;
      c.quantum_prescale = 6'($urandom % 4);
      if (c.prop_segment_len < 3'h2) c.prop_segment_len = 3'h2;
      if (c.phase1_len == 3'h0) c.phase1_len = 3'h1;
      if (c.phase2_len > c.prop_segment_len + c.phase1_len + 1) c.phase2_len = c.prop_segment_len;
      set_cfg(c);
      wait_stb(0);
      bit_len(spq(c) + ph2q(c), "bit length");
      check("sample point", s_ofs, spq(c));
      // any sync the level changes cause must leave the sampled value intact
      BUS_IDLE <= 1'($urandom);
      TX_DOMINANT <= 1'($urandom);
      repeat (3) begin
        v = 1'($urandom);
        node.level(v);
        wait_stb(1);
        check("sampled bit", SAMPLE_BIT, v);
        wait_stb(0);
      end
      node.level(1'b1);
    end
    BUS_IDLE <= 1'b0;
    TX_DOMINANT <= 1'b0;
    wr(`CBT_OFS_TIME0, 8'hff);
    rd(`CBT_OFS_TIME0, d);
    check("locked reg", d, {c.jump_width, c.quantum_prescale});
    // a frozen core stretches the bit by exactly the frozen cycles
    wait_stb(0);
    nom = 1 + $urandom % 20;
    CE <= 1'b0;
    repeat (nom) @(posedge CORE_CLK);
    CE <= 1'b1;
    bit_len(spq(c) + ph2q(c) + nom, "frozen bit");
    // recessive level from just before the sample point inside a dominant bit
    for (int t = 0; t < 2; t++) begin
      set_cfg({2'h0, 6'h07, 1'b0, 1'(t), 3'h1, 3'h3, 3'h0});
      node.level(1'b0);
      wait_stb(0);
      wait_stb(0);
      repeat (109) @(posedge CORE_CLK);
      node.level(1'b1);
      wait_stb(1);
      check("glitch vote", SAMPLE_BIT, t == 0);
      node.level(1'b1);
    end
    // q = 4 clocks, 17 quanta per bit, phase 1 ends at quantum 9
    for (int w = 0; w < 4; w++) begin
      set_cfg({2'(w), 6'h01, 1'b1, 1'b0, 3'h3, 3'h3, 3'h7});
      nom = 68;
      BUS_IDLE <= 1'b1;
      // a recessive sample must come first or the edge is refused
      wait_stb(1);
      repeat ($urandom % 40) @(posedge CORE_CLK);
      node.level(1'b0);
      hit = 1'b0;
      repeat (4) begin
        @(posedge CORE_CLK);
        hit |= BIT_START_STB;
      end
      check("hard sync", hit, 1'b1);
      node.level(1'b1);
      repeat (4) @(posedge CORE_CLK);
      node.pulse(4);
      bit_len(nom, "after hard sync");
      BUS_IDLE <= 1'b0;
      wait_stb(0);
      repeat (29) @(posedge CORE_CLK);
      node.pulse(4);
      bit_len(nom + 4 * (w + 1), "late edge");
      wait_stb(0);
      repeat (41) @(posedge CORE_CLK);
      node.pulse(4);
      bit_len(nom - 4 * (w + 1), "early edge");
      TX_DOMINANT <= 1'b1;
      repeat (29) @(posedge CORE_CLK);
      node.pulse(4);
      bit_len(nom, "sending dominant");
      TX_DOMINANT <= 1'b0;
      repeat (5) @(posedge CORE_CLK);
      node.pulse(4);
      check("small error", len, 8);
      bit_len(nom, "after restart");
      node.level(1'b0);
      wait_stb(0);
      wait_stb(0);
      node.level(1'b1);
      repeat (29) @(posedge CORE_CLK);
      node.level(1'b0);
      bit_len(nom, "after dominant");
      node.level(1'b1);
      wait_stb(0);
    end
    end_sim();
  end
endmodule
`default_nettype wire
